// file: rtl/sarcc_pkg.sv
package sarcc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] CONFIG_ADDR = 8'h04;
    localparam logic [7:0] RESHI_ADDR  = 8'h08;
    localparam logic [7:0] RESLO_ADDR  = 8'h0C;
    localparam logic [7:0] TRIG_ADDR   = 8'h10;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_EN_BIT    = 7;
    localparam int CTRL_TRACK_BIT = 6;
    localparam int CTRL_DONE_BIT  = 5;
    localparam int CTRL_BUSY_BIT  = 4;
    localparam int CTRL_SRC_LSB   = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Config register fields
    // ------------------------------------------------------------------
    localparam int CFG_DIV_LSB   = 3;
    localparam int CFG_EIGHT_BIT = 2;
    localparam int CFG_LJST_BIT  = 1;
    localparam logic [7:0] CFG_RESET = 8'hF8;

    // Trigger register fields
    localparam int TRIG_T2_WIDE_BIT = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CORE_CLK_HZ     = 20_000_000;
    localparam int MAX_RATE_SPS    = 500_000;
    localparam logic [5:0] MIN_PERIOD_CYC =
        6'(CORE_CLK_HZ / MAX_RATE_SPS);
    localparam logic [3:0] BITS_TEN   = 4'hA;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] TRACK_CYC  = 4'h3;
    localparam logic [3:0] SAR_OVERHEAD = 4'h1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SARCC_SRC_SW    = 3'h0,
        SARCC_SRC_TMR0  = 3'h1,
        SARCC_SRC_TMR2  = 3'h2,
        SARCC_SRC_TMR1  = 3'h3,
        SARCC_SRC_PIN   = 3'h4
    } sarcc_src_e;

    typedef enum logic [3:0] {
        SARCC_OFF   = 4'h1,
        SARCC_TRACK = 4'h2,
        SARCC_DELAY = 4'h4,
        SARCC_CONV  = 4'h8
    } sarcc_state_e;

    typedef struct packed {
        logic        t0_ovf;
        logic        t1_ovf;
        logic        t2_lo_ovf;
        logic        t2_hi_ovf;
    } sarcc_timers_s;

    typedef struct packed {
        logic        sample;
        logic        track;
        logic [9:0]  code;
    } sarcc_analog_s;

endpackage : sarcc_pkg

// file: rtl/sarcc_pin_sync.sv
`timescale 1ns/100ps
module sarcc_pin_sync
    import sarcc_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Pin in, filtered level out
    input  wire logic pin_i,
    output logic      level_o
);

    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } sarcc_sync_s;

    sarcc_sync_s st;
    sarcc_sync_s next_st;

    // Level changes only once stages two and three agree
    always_comb begin
        next_st       = st;
        next_st.stage = {st.stage[1:0], pin_i};
        if (st.stage[1] == st.stage[2]) begin
            next_st.level = st.stage[2];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.level;

endmodule : sarcc_pin_sync

// file: rtl/sarcc_top.sv
// Functional notes
// - Converter runs only while enable is 1; otherwise shut down.
// - Each finished conversion loads result high and low bytes.
// - Full-resolution results are 10-bit unsigned integers.
// - Justify 0 right-aligns (03FF); justify 1 left-aligns (FFC0).
// - Result bits unused by the alignment read as zero.
// - Eight-bit mode converts 8 MSBs into the high byte only.
// - Eight-bit mode ignores the justify bit.
// - Eight-bit conversions take two fewer conversion clocks.
// - Conversion clock is core clock divided by config field plus one.
// - Conversion rate never exceeds 500 ksps.
// - Start source field picks software, timers or pin edge.
// - In software mode, writing busy 1 starts a conversion.
// - Busy reads 1 during conversion, 0 when it completes.
// - Busy falling at completion sets done flag and raises interrupt if enabled.
// - Results are valid whenever the done flag reads 1.
// - Timer 2 trigger uses low or high byte overflow by timer mode.
// - Delayed tracking adds three conversion clocks before converting.
// - Without delayed tracking, conversion starts right at trigger.
// - Internal triggers: track whenever enabled and not converting.
// - Pin trigger: track if delayed bit, or pin low.
`timescale 1ns/100ps
module sarcc_top
    import sarcc_pkg::*;
(
    // Clock and reset
    input  wire logic          CORE_CLK_I,
    input  wire logic          RSTN_I,
    // AHB-Lite slave
    input  wire logic          HSEL_I,
    input  wire logic [7:0]    HADDR_I,
    input  wire logic [1:0]    HTRANS_I,
    input  wire logic          HWRITE_I,
    input  wire logic [2:0]    HSIZE_I,
    input  wire logic [31:0]   HWDATA_I,
    input  wire logic          HREADY_I,
    output logic [31:0]        HRDATA_O,
    output logic               HREADYOUT_O,
    output logic               HRESP_O,
    // Trigger sources
    input  wire sarcc_timers_s TIMERS_I,
    input  wire logic          EXT_START_PIN_I,
    // Interrupt enable and request
    input  wire logic          INT_ENABLE_I,
    output logic               INT_REQ_O,
    // Analog core
    input  wire logic [9:0]    SAR_CODE_I,
    output sarcc_analog_s      ANALOG_O,
    output logic               SHUTDOWN_O
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        sarcc_state_e fsm;
        logic [7:0]   ctrl;
        logic [7:0]   cfg;
        logic         t2_wide;
        logic [7:0]   res_hi;
        logic [7:0]   res_lo;
        logic [4:0]   div_cnt;
        logic [3:0]   step;
        logic [5:0]   gap_cnt;
        logic         pin_prev;
        logic         start_req;
        logic         irq;
        logic         ad_valid;
        logic [7:0]   ad_addr;
        logic         ad_write;
        logic [31:0]  rdata;
    } sarcc_s;

    sarcc_s st;
    sarcc_s next_st;

    logic       pin_level;
    logic       tick;
    logic       trig;
    logic [3:0] conv_len;
    logic [9:0] code;
    logic       rd_take;
    logic       wr_now;
    logic       enabled;
    logic       eight;

    sarcc_pin_sync u_pin_sync (
        .clk_i   (CORE_CLK_I),
        .rstn_i  (RSTN_I),
        .pin_i   (EXT_START_PIN_I),
        .level_o (pin_level)
    );

    // ------------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------------
    assign enabled  = st.ctrl[CTRL_EN_BIT];
    assign eight    = st.cfg[CFG_EIGHT_BIT];
    assign tick     = (st.div_cnt >= st.cfg[7:CFG_DIV_LSB]);
    assign conv_len = (eight ? BITS_EIGHT : BITS_TEN) + SAR_OVERHEAD;
    assign code     = SAR_CODE_I;
    assign rd_take  = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;
    assign wr_now   = st.ad_valid && st.ad_write;

    always_comb begin
        case (sarcc_src_e'(st.ctrl[CTRL_SRC_LSB+:3]))
            SARCC_SRC_SW:   trig = st.start_req;
            SARCC_SRC_TMR0: trig = TIMERS_I.t0_ovf;
            SARCC_SRC_TMR2: trig = st.t2_wide ? TIMERS_I.t2_hi_ovf
                                              : TIMERS_I.t2_lo_ovf;
            SARCC_SRC_TMR1: trig = TIMERS_I.t1_ovf;
            SARCC_SRC_PIN:  trig = pin_level && !st.pin_prev;
            default:        trig = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st          = st;
        next_st.irq      = 1'b0;
        next_st.pin_prev = pin_level;
        next_st.ad_valid = HSEL_I && HREADY_I && HTRANS_I[1];
        next_st.ad_addr  = HADDR_I;
        next_st.ad_write = HWRITE_I;
        next_st.div_cnt  = tick ? 5'h00 : st.div_cnt + 5'h01;
        if (st.gap_cnt != 6'h00) begin
            next_st.gap_cnt = st.gap_cnt - 6'h01;
        end

        // Register writes
        if (wr_now) begin
            case (st.ad_addr)
                CTRL_ADDR: begin
                    next_st.ctrl[CTRL_EN_BIT]    = HWDATA_I[CTRL_EN_BIT];
                    next_st.ctrl[CTRL_TRACK_BIT] = HWDATA_I[CTRL_TRACK_BIT];
                    next_st.ctrl[CTRL_SRC_LSB+:3] = HWDATA_I[2:0];
                    if (!HWDATA_I[CTRL_DONE_BIT]) begin
                        next_st.ctrl[CTRL_DONE_BIT] = 1'b0;
                    end
                    if (HWDATA_I[CTRL_BUSY_BIT] &&
                        HWDATA_I[2:0] == 3'(SARCC_SRC_SW)) begin
                        next_st.start_req = 1'b1;
                    end
                end
                CONFIG_ADDR: next_st.cfg = {HWDATA_I[7:1], 1'b0};
                TRIG_ADDR:   next_st.t2_wide = HWDATA_I[TRIG_T2_WIDE_BIT];
                default: ;
            endcase
        end

        case (st.fsm)
            SARCC_OFF: begin
                next_st.start_req = 1'b0;
                if (enabled) begin
                    next_st.fsm = SARCC_TRACK;
                end
            end
            SARCC_TRACK: begin
                if (trig && st.gap_cnt == 6'h00) begin
                    next_st.start_req            = 1'b0;
                    next_st.ctrl[CTRL_BUSY_BIT]  = 1'b1;
                    next_st.gap_cnt              = MIN_PERIOD_CYC;
                    next_st.step                 = 4'h0;
                    next_st.fsm = st.ctrl[CTRL_TRACK_BIT] ? SARCC_DELAY
                                                          : SARCC_CONV;
                end
            end
            SARCC_DELAY: begin
                if (tick) begin
                    next_st.step = st.step + 4'h1;
                    if (st.step == TRACK_CYC - 4'h1) begin
                        next_st.step = 4'h0;
                        next_st.fsm  = SARCC_CONV;
                    end
                end
            end
            SARCC_CONV: begin
                if (tick) begin
                    next_st.step = st.step + 4'h1;
                    if (st.step == conv_len - 4'h1) begin
                        next_st.fsm = SARCC_TRACK;
                        next_st.ctrl[CTRL_BUSY_BIT] = 1'b0;
                        next_st.ctrl[CTRL_DONE_BIT] = 1'b1;
                        next_st.irq = INT_ENABLE_I;
                        if (eight) begin
                            next_st.res_hi = code[9:2];
                            next_st.res_lo = 8'h00;
                        end else if (st.cfg[CFG_LJST_BIT]) begin
                            next_st.res_hi = code[9:2];
                            next_st.res_lo = {code[1:0], 6'h00};
                        end else begin
                            next_st.res_hi = {6'h00, code[9:8]};
                            next_st.res_lo = code[7:0];
                        end
                    end
                end
            end
            default: next_st.fsm = SARCC_OFF;
        endcase

        if (!enabled && !(wr_now && st.ad_addr == CTRL_ADDR &&
                          HWDATA_I[CTRL_EN_BIT])) begin
            next_st.fsm                 = SARCC_OFF;
            next_st.ctrl[CTRL_BUSY_BIT] = 1'b0;
            next_st.step                = 4'h0;
        end

        // Read data
        next_st.rdata = 32'h0000_0000;
        if (rd_take) begin
            case (HADDR_I)
                CTRL_ADDR:   next_st.rdata = {24'h00_0000, next_st.ctrl};
                CONFIG_ADDR: next_st.rdata = {24'h00_0000, next_st.cfg};
                RESHI_ADDR:  next_st.rdata = {24'h00_0000, next_st.res_hi};
                RESLO_ADDR:  next_st.rdata = {24'h00_0000, next_st.res_lo};
                TRIG_ADDR:   next_st.rdata = {31'h0, next_st.t2_wide};
                default:     next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st         <= '0;
            st.fsm     <= SARCC_OFF;
            st.ctrl    <= CTRL_RESET;
            st.cfg     <= CFG_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign HRDATA_O    = st.rdata;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;
    assign INT_REQ_O   = st.irq;
    assign SHUTDOWN_O  = (st.fsm == SARCC_OFF);

    always_comb begin
        ANALOG_O.code   = st.res_hi[7:0] == 8'h00 ? 10'h000 : 10'h000;
        ANALOG_O.sample = (st.fsm == SARCC_CONV);
        if (st.ctrl[CTRL_SRC_LSB+:3] == 3'(SARCC_SRC_PIN)) begin
            ANALOG_O.track = (st.fsm == SARCC_DELAY) ||
                             ((st.fsm == SARCC_TRACK) &&
                              (st.ctrl[CTRL_TRACK_BIT] || !pin_level));
        end else begin
            ANALOG_O.track = (st.fsm == SARCC_TRACK) ||
                             (st.fsm == SARCC_DELAY);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_shutdown;
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        !enabled |=> SHUTDOWN_O || enabled;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("converter active while disabled");

    property p_busy_fall_done;
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        $fell(st.ctrl[CTRL_BUSY_BIT]) && enabled
            |-> st.ctrl[CTRL_DONE_BIT];
    endproperty
    a_busy_fall_done: assert property (p_busy_fall_done)
        else $error("busy fell without done flag");

    property p_eight_lo_zero;
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        $rose(st.ctrl[CTRL_DONE_BIT]) && eight |-> st.res_lo == 8'h00;
    endproperty
    a_eight_lo_zero: assert property (p_eight_lo_zero)
        else $error("eight bit result leaked into low byte");

    property p_right_zero;
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        $rose(st.ctrl[CTRL_DONE_BIT]) && !eight && !st.cfg[CFG_LJST_BIT]
            |-> st.res_hi[7:2] == 6'h00;
    endproperty
    a_right_zero: assert property (p_right_zero)
        else $error("unused high bits not zero");

    property p_left_zero;
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        $rose(st.ctrl[CTRL_DONE_BIT]) && !eight && st.cfg[CFG_LJST_BIT]
            |-> st.res_lo[5:0] == 6'h00;
    endproperty
    a_left_zero: assert property (p_left_zero)
        else $error("unused low bits not zero");

    property p_no_direct_conv;
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        st.fsm == SARCC_TRACK && $past(st.fsm) == SARCC_TRACK
            && st.ctrl[CTRL_TRACK_BIT] ##1 st.fsm != SARCC_TRACK
            |-> st.fsm == SARCC_DELAY || st.fsm == SARCC_OFF;
    endproperty
    a_no_direct_conv: assert property (p_no_direct_conv)
        else $error("delayed mode skipped tracking");

    property p_busy_in_conv;
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        st.fsm == SARCC_CONV |-> st.ctrl[CTRL_BUSY_BIT];
    endproperty
    a_busy_in_conv: assert property (p_busy_in_conv)
        else $error("busy low during conversion");

    property p_gap;
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        $rose(st.ctrl[CTRL_BUSY_BIT]) |-> st.gap_cnt == MIN_PERIOD_CYC;
    endproperty
    a_gap: assert property (p_gap)
        else $error("conversion spacing not armed");

    property p_gap_free;
        @(posedge CORE_CLK_I) disable iff (!RSTN_I)
        $rose(st.ctrl[CTRL_BUSY_BIT]) |-> $past(st.gap_cnt) == 6'h00;
    endproperty
    a_gap_free: assert property (p_gap_free)
        else $error("conversion started inside spacing window");

endmodule : sarcc_top

// file: tb/sarcc_analog_model.sv
`timescale 1ns/100ps
module sarcc_analog_model
    import sarcc_pkg::*;
(
    // Controls from the block
    input  wire sarcc_analog_s analog_i,
    // Input level set by the bench
    input  wire logic [9:0]    level_i,
    // Code returned to the block
    output logic [9:0]         code_o
);
    // Code is only valid while sampling; otherwise show the inverse
    assign code_o = analog_i.sample ? level_i : ~level_i;
endmodule : sarcc_analog_model

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench
    import sarcc_pkg::*;
;
    logic          clk;
    logic          rstn;
    logic          hsel;
    logic [7:0]    haddr;
    logic [1:0]    htrans;
    logic          hwrite;
    logic [2:0]    hsize;
    logic [31:0]   hwdata;
    logic [31:0]   hrdata;
    logic          hready;
    logic          hresp;
    sarcc_timers_s timers;
    logic          pin;
    logic          int_en;
    logic          int_req;
    logic [9:0]    lvl;
    logic [9:0]    code;
    sarcc_analog_s analog;
    logic          shutdown;
    int            failures;
    int            tests_run;
    int            cyc = 0;
    int            d [4];
    logic [31:0]   x;

    sarcc_top sarcc_top_inst (
        .CORE_CLK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .TIMERS_I(timers),
        .EXT_START_PIN_I(pin), .INT_ENABLE_I(int_en), .INT_REQ_O(int_req),
        .SAR_CODE_I(code), .ANALOG_O(analog), .SHUTDOWN_O(shutdown)
    );

    sarcc_analog_model sarcc_analog_model_inst (
        .analog_i(analog), .level_i(lvl), .code_o(code)
    );

    always #25 clk = ~clk;

    // ------------------------------------------------------------------
    // Timeout and closing report
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] unused;
        xfer(1'b1, a, wd, unused);
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] m, input logic [31:0] e);
        logic [31:0] rd;
        xfer(1'b0, a, 32'h0, rd);
        chk(nm, e, rd & m);
    endtask : rdchk

    task automatic rdres(input logic [9:0] c, input logic e8,
                         input logic lj);
        logic [15:0] r;
        if (e8) r = {c[9:2], 8'h00};
        else if (lj) r = {c, 6'h00};
        else r = {6'h00, c};
        rdchk("result_high", RESHI_ADDR, 32'hFFFFFFFF, {24'h0, r[15:8]});
        rdchk("result_low", RESLO_ADDR, 32'hFFFFFFFF, {24'h0, r[7:0]});
    endtask : rdres

    // Start by write, timer pulse or pin; return cycles to interrupt
    task automatic conv(input logic [7:0] ctl, input logic [3:0] tp,
                        input logic p, input logic [9:0] c,
                        output int dur);
        int t0;
        repeat (45) @(posedge clk);
        lvl <= c;
        wr(CTRL_ADDR, {24'h0, ctl});
        if (tp != 4'h0) begin
            timers <= sarcc_timers_s'(tp);
            @(posedge clk);
            timers <= '0;
        end
        if (p) pin <= 1'b1;
        t0 = cyc;
        if (ctl[4])
            rdchk("busy_during", CTRL_ADDR, 32'h30,
                  32'({ctl[5], 1'b1, 4'h0}));
        dur = -1;
        for (int i = 0; i < 300 && dur < 0; i++) begin
            @(posedge clk);
            if (int_req === 1'b1) dur = cyc - t0;
        end
    endtask : conv

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    logic       e8_t [3] = '{1'b0, 1'b0, 1'b1};
    logic       lj_t [3] = '{1'b0, 1'b1, 1'b1};
    logic [9:0] c_t  [3] = '{10'h3FF, 10'h201, 10'h2AB};
    logic [2:0] src_t [4] = '{3'h1, 3'h2, 3'h2, 3'h3};
    logic [3:0] hit_t [4] = '{4'h8, 4'h2, 4'h1, 4'h4};
    logic       wide_t [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

    initial begin
        clk = 1'b0; rstn = 1'b0; hsel = 1'b0; haddr = 8'h00;
        htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        timers = '0; pin = 1'b0; int_en = 1'b1; lvl = 10'h000;
        failures = 0; tests_run = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;

        rdchk("ctrl_reset", CTRL_ADDR, 32'hFF, {24'h0, CTRL_RESET});
        rdchk("config_reset", CONFIG_ADDR, 32'hFF, {24'h0, CFG_RESET});
        rdres(10'h000, 1'b0, 1'b0);
        rdchk("unmapped", 8'h14, 32'hFFFFFFFF, 32'h0);
        chk("shutdown_off", 32'h1, {31'h0, shutdown});
        $display("test reset finished");

        wr(CTRL_ADDR, 32'h80);
        for (int i = 0; i < 3; i++) begin
            wr(CONFIG_ADDR, {29'h0, e8_t[i], lj_t[i], 1'b0});
            conv(8'h90, 4'h0, 1'b0, c_t[i], d[i]);
            rdchk("done_set", CTRL_ADDR, 32'h30, 32'h20);
            rdres(c_t[i], e8_t[i], lj_t[i]);
        end
        chk("shutdown_on", 32'h0, {31'h0, shutdown});
        chk("eight_bit_time", 32'(d[0] - 2), 32'(d[2]));
        wr(CONFIG_ADDR, 32'h0);
        conv(8'hD0, 4'h0, 1'b0, 10'h155, d[3]);
        chk("delayed_time", 32'(d[0] + 3), 32'(d[3]));
        rdres(10'h155, 1'b0, 1'b0);
        chk("track_idle", 32'h1, {31'h0, analog.track});
        wr(CONFIG_ADDR, 32'h08);
        conv(8'h90, 4'h0, 1'b0, 10'h155, d[3]);
        chk("divided_time", 32'(d[0] - 1), 32'((d[3] + 1) / 2));
        wr(CONFIG_ADDR, 32'h0);
        $display("test formats finished");

        int_en <= 1'b0;
        conv(8'hB0, 4'h0, 1'b0, 10'h0AA, d[0]);
        chk("masked_int", 32'hFFFFFFFF, 32'(d[0]));
        int_en <= 1'b1;
        conv(8'hB0, 4'h0, 1'b0, 10'h0AA, d[0]);
        wr(CTRL_ADDR, 32'h80);
        rdchk("done_cleared", CTRL_ADDR, 32'h30, 32'h00);
        wr(CTRL_ADDR, 32'h90);
        rdchk("rate_hold", CTRL_ADDR, 32'h30, 32'h00);
        repeat (60) @(posedge clk);
        rdchk("rate_late_start", CTRL_ADDR, 32'h30, 32'h20);
        $display("test flag finished");

        for (int i = 0; i < 4; i++) begin
            wr(TRIG_ADDR, {31'h0, wide_t[i]});
            wr(CTRL_ADDR, {24'h0, 5'h10, src_t[i]});
            timers <= sarcc_timers_s'(~hit_t[i]);
            @(posedge clk);
            timers <= '0;
            repeat (30) @(posedge clk);
            rdchk("stray_start", CTRL_ADDR, 32'h30, 32'h0);
            conv({5'h10, src_t[i]}, hit_t[i], 1'b0, 10'h100, d[0]);
            chk("timer_start", 32'h1, 32'(d[0] > 0));
        end
        wr(CTRL_ADDR, 32'h84);
        repeat (5) @(posedge clk);
        chk("track_pin_low", 32'h1, {31'h0, analog.track});
        conv(8'h84, 4'h0, 1'b1, 10'h333, d[0]);
        chk("pin_start", 32'h1, 32'(d[0] > 0));
        rdres(10'h333, 1'b0, 1'b0);
        chk("track_pin_high", 32'h0, {31'h0, analog.track});
        pin <= 1'b0;
        $display("test triggers finished");

        wr(CTRL_ADDR, 32'h0);
        repeat (3) @(posedge clk);
        chk("shutdown_again", 32'h1, {31'h0, shutdown});
        wr(CTRL_ADDR, 32'h10);
        repeat (60) @(posedge clk);
        rdchk("no_start_off", CTRL_ADDR, 32'h30, 32'h0);
        $display("test disable finished");
        test_done();
    end
endmodule : testbench
